// >>> rtl/nvc_pkg.sv
package nvc_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int ACCESS_TIME_NS = 45;
   localparam int STORE_DURATION_MS = 10;
   localparam int RECALL_DURATION_US = 20;
   localparam int POWERUP_RECALL_DURATION_US = 550;
   localparam int STORE_PULSE_NS = 15;
   localparam int STORE_BUSY_DELAY_NS = 300;
   localparam int STORE_RECOVER_NS = 700;
   localparam int SYNC_DEPTH = 2;

   localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;
   localparam int STROBE_CYC = ACCESS_CYC + SYNC_DEPTH;
   localparam int STORE_CYC = (STORE_DURATION_MS * 1000000 +
      CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECALL_CYC = (RECALL_DURATION_US * 1000 +
      CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESTORE_CYC = (POWERUP_RECALL_DURATION_US * 1000 +
      CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (STORE_PULSE_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;
   localparam int BUSY_CYC = (STORE_BUSY_DELAY_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS + SYNC_DEPTH;
   localparam int RECOVER_CYC = (STORE_RECOVER_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Memory geometry and sequence addresses
   // ------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CNT_W = 24;
   localparam int SEQ_LAST = 5;
   localparam logic [ADDR_W-1:0] SEQ_A0 = 15'h0E38;
   localparam logic [ADDR_W-1:0] SEQ_A1 = 15'h31C7;
   localparam logic [ADDR_W-1:0] SEQ_A2 = 15'h03E0;
   localparam logic [ADDR_W-1:0] SEQ_A3 = 15'h3C1F;
   localparam logic [ADDR_W-1:0] SEQ_A4 = 15'h303F;
   localparam logic [ADDR_W-1:0] SEQ_STORE = 15'h0FC0;
   localparam logic [ADDR_W-1:0] SEQ_RECALL = 15'h0C63;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_READ,
      CMD_WRITE,
      CMD_SW_STORE,
      CMD_SW_RECALL,
      CMD_HW_STORE
   } nvc_cmd_type;

   typedef enum logic [3:0] {
      ST_BOOT,
      ST_IDLE,
      ST_STROBE,
      ST_GAP,
      ST_WAIT,
      ST_PULSE,
      ST_WATCH,
      ST_BUSY,
      ST_RECOVER
   } nvc_state_type;

   typedef struct packed {
      nvc_cmd_type cmd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } nvc_req_type;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic dq_oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
      logic hsb_oe_n;
   } nvc_pins_type;

endpackage : nvc_pkg

// >>> rtl/nvc_host.sv
module nvc_host #(
   parameter int STORE_WAIT_CYC = nvc_pkg::STORE_CYC,
   parameter int RESTORE_WAIT_CYC = nvc_pkg::RESTORE_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_req_valid,
   input wire nvc_pkg::nvc_req_type i_req,
   output logic o_req_ready,
   output logic o_busy,
   output logic o_done,
   output logic o_rdata_valid,
   output logic [nvc_pkg::DATA_W-1:0] o_rdata,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [nvc_pkg::ADDR_W-1:0] o_addr,
   output logic [nvc_pkg::DATA_W-1:0] o_dq_out,
   output logic o_dq_oe_n,
   input wire logic [nvc_pkg::DATA_W-1:0] i_dq_in,
   output logic o_hsb_out,
   output logic o_hsb_oe_n,
   input wire logic i_hsb_in
);

   if (STORE_WAIT_CYC < 1 || STORE_WAIT_CYC >= (1 << nvc_pkg::CNT_W))
   begin : g_bad_store_wait
      $error("STORE_WAIT_CYC out of range");
   end
   if (RESTORE_WAIT_CYC < 1 ||
       RESTORE_WAIT_CYC >= (1 << nvc_pkg::CNT_W)) begin : g_bad_restore
      $error("RESTORE_WAIT_CYC out of range");
   end

   typedef struct packed {
      nvc_pkg::nvc_state_type st;
      logic [nvc_pkg::CNT_W-1:0] cnt;
      logic [2:0] step;
      logic seq;
      logic recall;
      logic wr;
      nvc_pkg::nvc_pins_type pins;
      logic [nvc_pkg::DATA_W-1:0] rdata;
      logic rvalid;
      logic done;
   } nvc_host_state_type;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [nvc_pkg::ADDR_W-1:0] seq_addr(
      input logic [2:0] step,
      input logic recall
   );
      logic [nvc_pkg::ADDR_W-1:0] a;
      case (step)
         3'h0: a = nvc_pkg::SEQ_A0;
         3'h1: a = nvc_pkg::SEQ_A1;
         3'h2: a = nvc_pkg::SEQ_A2;
         3'h3: a = nvc_pkg::SEQ_A3;
         3'h4: a = nvc_pkg::SEQ_A4;
         default: a = recall ? nvc_pkg::SEQ_RECALL : nvc_pkg::SEQ_STORE;
      endcase
      // Top bit is ignored by the device; drive it low
      a[nvc_pkg::ADDR_W-1] = 1'b0;
      return a;
   endfunction : seq_addr

   function automatic logic [nvc_pkg::CNT_W-1:0] cyc(input int n);
      return nvc_pkg::CNT_W'(n - 1);
   endfunction : cyc

   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_sync;
   logic rst_n;
   logic hsb_s1;
   logic hsb_s2;
   logic [nvc_pkg::DATA_W-1:0] dq_s1;
   logic [nvc_pkg::DATA_W-1:0] dq_s2;

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hsb_s1 <= 1'b0;
         hsb_s2 <= 1'b0;
         dq_s1 <= 8'h00;
         dq_s2 <= 8'h00;
      end else begin
         hsb_s1 <= i_hsb_in;
         hsb_s2 <= hsb_s1;
         dq_s1 <= i_dq_in;
         dq_s2 <= dq_s1;
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   localparam nvc_pkg::nvc_pins_type PINS_IDLE = '{ce_n: 1'b1,
      oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1, addr: 15'h0000,
      dq: 8'h00, hsb_oe_n: 1'b1};

   nvc_host_state_type r;
   nvc_host_state_type next_r;
   logic accept;

   // Nothing new starts while the request line is low
   assign accept = (r.st == nvc_pkg::ST_IDLE) && hsb_s2;

   always_comb begin
      next_r = r;
      next_r.rvalid = 1'b0;
      next_r.done = 1'b0;
      case (r.st)
         nvc_pkg::ST_BOOT: begin
            // Power-up recall in progress
            if (r.cnt == '0) begin
               next_r.st = nvc_pkg::ST_IDLE;
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         nvc_pkg::ST_IDLE: begin
            if (i_req_valid && accept) begin
               next_r.wr = (i_req.cmd == nvc_pkg::CMD_WRITE);
               next_r.seq = (i_req.cmd == nvc_pkg::CMD_SW_STORE) ||
                  (i_req.cmd == nvc_pkg::CMD_SW_RECALL);
               next_r.recall = (i_req.cmd == nvc_pkg::CMD_SW_RECALL);
               next_r.step = 3'h0;
               if (i_req.cmd == nvc_pkg::CMD_HW_STORE) begin
                  next_r.st = nvc_pkg::ST_PULSE;
                  next_r.cnt = cyc(nvc_pkg::PULSE_CYC);
                  next_r.pins.hsb_oe_n = 1'b0;
               end else begin
                  next_r.st = nvc_pkg::ST_STROBE;
                  next_r.cnt = cyc(nvc_pkg::STROBE_CYC);
                  next_r.pins.ce_n = 1'b0;
                  next_r.pins.dq = i_req.wdata;
                  if (i_req.cmd == nvc_pkg::CMD_WRITE) begin
                     next_r.pins.addr = i_req.addr;
                     next_r.pins.we_n = 1'b0;
                     next_r.pins.oe_n = 1'b1;
                     next_r.pins.dq_oe_n = 1'b0;
                  end else if (i_req.cmd == nvc_pkg::CMD_READ) begin
                     next_r.pins.addr = i_req.addr;
                     next_r.pins.oe_n = 1'b0;
                  end else begin
                     // Sequence steps are plain reads, outputs off
                     next_r.pins.addr = seq_addr(3'h0,
                        i_req.cmd == nvc_pkg::CMD_SW_RECALL);
                     next_r.pins.oe_n = 1'b1;
                  end
               end
            end
         end
         nvc_pkg::ST_STROBE: begin
            // Exactly one chip enable fall per access
            if (r.cnt == '0) begin
               next_r.st = nvc_pkg::ST_GAP;
               next_r.pins.ce_n = 1'b1;
               next_r.pins.oe_n = 1'b1;
               next_r.pins.we_n = 1'b1;
               next_r.pins.dq_oe_n = 1'b1;
               if (!r.wr && !r.seq) begin
                  next_r.rdata = dq_s2;
               end
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         nvc_pkg::ST_GAP: begin
            if (r.seq && r.step != 3'(nvc_pkg::SEQ_LAST)) begin
               // Steps issued back to back, one chip-enable-high cycle (ST_GAP) in between
               next_r.step = r.step + 3'h1;
               next_r.pins.addr = seq_addr(r.step + 3'h1,
                  r.recall);
               next_r.pins.ce_n = 1'b0;
               next_r.st = nvc_pkg::ST_STROBE;
               next_r.cnt = cyc(nvc_pkg::STROBE_CYC);
            end else if (r.seq) begin
               next_r.st = nvc_pkg::ST_WAIT;
               next_r.cnt = r.recall ? cyc(nvc_pkg::RECALL_CYC) :
                  cyc(STORE_WAIT_CYC);
            end else begin
               next_r.st = nvc_pkg::ST_IDLE;
               next_r.rvalid = !r.wr;
               next_r.done = 1'b1;
            end
         end
         nvc_pkg::ST_WAIT: begin
            if (r.cnt == '0) begin
               next_r.st = nvc_pkg::ST_IDLE;
               next_r.done = 1'b1;
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         nvc_pkg::ST_PULSE: begin
            if (r.cnt == '0) begin
               next_r.pins.hsb_oe_n = 1'b1;
               next_r.st = nvc_pkg::ST_WATCH;
               next_r.cnt = cyc(nvc_pkg::BUSY_CYC);
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         nvc_pkg::ST_WATCH: begin
            // Give the device time to assert busy, if it stores at all
            if (r.cnt == '0) begin
               next_r.st = nvc_pkg::ST_BUSY;
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         nvc_pkg::ST_BUSY: begin
            if (hsb_s2) begin
               next_r.st = nvc_pkg::ST_RECOVER;
               next_r.cnt = cyc(nvc_pkg::RECOVER_CYC);
            end
         end
         nvc_pkg::ST_RECOVER: begin
            if (r.cnt == '0) begin
               next_r.st = nvc_pkg::ST_IDLE;
               next_r.done = 1'b1;
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         default: begin
            next_r.st = nvc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r.st <= nvc_pkg::ST_BOOT;
         r.cnt <= cyc(RESTORE_WAIT_CYC);
         r.step <= 3'h0;
         r.seq <= 1'b0;
         r.recall <= 1'b0;
         r.wr <= 1'b0;
         r.pins <= PINS_IDLE;
         r.rdata <= 8'h00;
         r.rvalid <= 1'b0;
         r.done <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_req_ready = accept;
   assign o_busy = (r.st != nvc_pkg::ST_IDLE) || !hsb_s2;
   assign o_done = r.done;
   assign o_rdata_valid = r.rvalid;
   assign o_rdata = r.rdata;
   assign o_ce_n = r.pins.ce_n;
   assign o_oe_n = r.pins.oe_n;
   assign o_we_n = r.pins.we_n;
   assign o_addr = r.pins.addr;
   assign o_dq_out = r.pins.dq;
   assign o_dq_oe_n = r.pins.dq_oe_n;
   assign o_hsb_out = 1'b0;
   assign o_hsb_oe_n = r.pins.hsb_oe_n;

endmodule : nvc_host

// >>> sim/nvc_host_asserts.sv
module nvc_host_asserts (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic o_req_ready,
   input wire logic o_done,
   input wire logic o_rdata_valid,
   input wire logic o_ce_n,
   input wire logic o_oe_n,
   input wire logic o_we_n,
   input wire logic [nvc_pkg::ADDR_W-1:0] o_addr,
   input wire logic o_dq_oe_n,
   input wire logic o_hsb_out,
   input wire logic o_hsb_oe_n,
   input wire logic i_hsb_in
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);
   // ------------------------
   // Strobe shapes
   // ------------------------
   sequence s_ce_low;
      (!o_ce_n)[*4] ##1 o_ce_n;
   endsequence
   sequence s_we_low;
      (!o_we_n)[*4] ##1 (o_we_n && o_dq_oe_n);
   endsequence
   chk_no_contention:
      assert property (!o_dq_oe_n |-> o_oe_n) else $error("bus contention");
   chk_read_shape:
      assert property ($fell(o_oe_n) |-> !o_ce_n && o_we_n && o_dq_oe_n)
         else $error("bad read strobes");
   chk_read_done:
      assert property ($rose(o_oe_n) |-> o_ce_n ##1 (o_done && o_rdata_valid))
         else $error("read not answered");
   chk_write_done:
      assert property ($fell(o_we_n) |-> s_we_low ##1 (o_done && !o_rdata_valid))
         else $error("bad write cycle");
   chk_strobe_len:
      assert property ($fell(o_ce_n) |-> s_ce_low) else $error("bad strobe");
   chk_addr_hold:
      assert property (!o_ce_n && !$fell(o_ce_n) |-> $stable(o_addr))
         else $error("address moved");
   chk_ready_blocked:
      assert property ((!i_hsb_in)[*3] |-> !o_req_ready)
         else $error("ready while line low");
   chk_no_new_write:
      assert property ((!i_hsb_in)[*4] |=> !$fell(o_we_n))
         else $error("write while line low");
   chk_hsb_pulse:
      assert property ($fell(o_hsb_oe_n) |-> !o_hsb_out ##1 o_hsb_oe_n)
         else $error("bad request pulse");
endmodule : nvc_host_asserts
bind nvc_host nvc_host_asserts u_nvc_host_asserts (
   .i_ref_clk, .i_resetn, .o_req_ready, .o_done, .o_rdata_valid, .o_ce_n,
   .o_oe_n, .o_we_n, .o_addr, .o_dq_oe_n, .o_hsb_out, .o_hsb_oe_n,
   .i_hsb_in);

// >>> sim/nvc_dev_model.sv
module nvc_dev_model #(
   parameter int STORE_NS = 600,
   parameter int RECALL_NS = 2000,
   parameter int RESTORE_NS = 300,
   parameter int DRAIN_NS = 100
) (
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [nvc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [nvc_pkg::DATA_W-1:0] i_dq,
   output logic [nvc_pkg::DATA_W-1:0] o_dq,
   input wire logic i_hsb,
   output logic o_hsb_pull
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:32767];
   logic [7:0] nv [0:32767];
   logic [14:0] seq [0:4];
   logic [7:0] noise;
   logic busy, dirty, wr_act;
   int step, n_store;
   task automatic nv_cycle(input logic store);
      busy = 1'b1;
      o_hsb_pull = store;
      if (store) begin
         #(STORE_NS);
         nv = mem;
         n_store++;
      end else begin
         #(RECALL_NS);
         mem = nv;
      end
      dirty = 1'b0;
      o_hsb_pull = 1'b0;
      wait (i_hsb);
      busy = 1'b0;
   endtask : nv_cycle
   // ------------------------
   // Power-up recall, inhibit mode fixed
   // ------------------------
   initial begin
      seq = '{nvc_pkg::SEQ_A0, nvc_pkg::SEQ_A1, nvc_pkg::SEQ_A2,
         nvc_pkg::SEQ_A3, nvc_pkg::SEQ_A4};
      noise = 8'h5A;
      busy = 1'b1;
      step = 0;
      n_store = 0;
      o_hsb_pull = 1'b0;
      foreach (nv[i]) nv[i] = 8'h00;
      #(RESTORE_NS);
      mem = nv;
      dirty = 1'b0;
      busy = 1'b0;
   end
   always #20 noise = ~noise;
   // Released lines show a moving pattern
   assign o_dq = (!i_ce_n && !i_oe_n && i_we_n && i_hsb && !busy) ?
      mem[i_addr] : noise;
   assign wr_act = !i_ce_n && !i_we_n && i_hsb && !busy;
   always @(negedge wr_act) begin
      mem[i_addr] = i_dq;
      dirty = 1'b1;
   end
   always @(negedge i_ce_n) begin
      #1;
      if (!busy) begin
         if (!i_we_n) step = 0;
         else if (step == 5 && i_addr[13:0] == nvc_pkg::SEQ_STORE[13:0]) begin
            step = 0;
            fork nv_cycle(1'b1); join_none
         end else if (step == 5 &&
               i_addr[13:0] == nvc_pkg::SEQ_RECALL[13:0]) begin
            step = 0;
            fork nv_cycle(1'b0); join_none
         end else if (step < 5 && i_addr[13:0] == seq[step][13:0]) step++;
         else step = (i_addr[13:0] == seq[0][13:0]) ? 1 : 0;
      end
   end
   always @(negedge i_hsb) begin
      if (!busy && !o_hsb_pull) begin
         #(DRAIN_NS);
         if (dirty) nv_cycle(1'b1);
      end
   end
endmodule : nvc_dev_model

// >>> sim/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, resetn, req_valid, ready, done, ce_n, oe_n, we_n, dq_oe_n;
   logic hsb_out, hsb_oe_n, dev_pull, hsb_line, host_busy;
   logic [7:0] rdata, dq_out, dev_dq, dq_line, dq_late, got;
   logic [14:0] addr;
   nvc_pkg::nvc_req_type req;
   int bad_count, n_compared, stores;
   // Pull-up on the request line
   assign dq_line = dq_oe_n ? dev_dq : dq_out;
   assign #2 dq_late = dq_line;
   assign hsb_line = !(dev_pull || (!hsb_oe_n && !hsb_out));
   nvc_host #(.STORE_WAIT_CYC(20), .RESTORE_WAIT_CYC(10)) u_nvc_host (
      .i_ref_clk(clk), .i_resetn(resetn), .i_req_valid(req_valid),
      .i_req(req), .o_req_ready(ready), .o_busy(host_busy), .o_done(done),
      .o_rdata_valid(), .o_rdata(rdata), .o_ce_n(ce_n), .o_oe_n(oe_n),
      .o_we_n(we_n), .o_addr(addr), .o_dq_out(dq_out),
      .o_dq_oe_n(dq_oe_n), .i_dq_in(dq_line), .o_hsb_out(hsb_out),
      .o_hsb_oe_n(hsb_oe_n), .i_hsb_in(hsb_line));
   nvc_dev_model u_nvc_dev_model (.i_ce_n(ce_n), .i_oe_n(oe_n),
      .i_we_n(we_n), .i_addr(addr), .i_dq(dq_late), .o_dq(dev_dq),
      .i_hsb(hsb_line), .o_hsb_pull(dev_pull));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic finish_test;
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   task automatic check_byte(input string what, input logic [7:0] exp,
         input logic [7:0] seen);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check_byte
   task automatic check_stores(input int k);
      check_byte("store count", 8'(stores + k), 8'(u_nvc_dev_model.n_store));
   endtask : check_stores
   task automatic run_cmd(input nvc_pkg::nvc_cmd_type c,
         input logic [14:0] a, input logic [7:0] d);
      int n;
      @(negedge clk);
      req_valid = 1'b1;
      req = '{c, a, d};
      for (n = 0; n < 20000 && ready !== 1'b1; n++) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      for (n = 0; n < 20000 && done !== 1'b1; n++) @(negedge clk);
      got = rdata;
      if (n == 20000) bad_count++;
   endtask : run_cmd
   task automatic t_rw;
      logic [14:0] ta [3] = '{15'h0000, 15'h7FFF, 15'h2AAA};
      logic [7:0] td [3] = '{8'h3C, 8'hC3, 8'h55};
      for (int i = 0; i < 3; i++) run_cmd(nvc_pkg::CMD_WRITE, ta[i], td[i]);
      for (int i = 0; i < 3; i++) begin
         run_cmd(nvc_pkg::CMD_READ, ta[i], 8'h00);
         check_byte("read data", td[i], got);
         check_byte("busy at done", 8'h00, {7'h00, host_busy});
      end
   endtask : t_rw
   task automatic t_sw;
      stores = u_nvc_dev_model.n_store;
      run_cmd(nvc_pkg::CMD_WRITE, 15'h0123, 8'hA5);
      run_cmd(nvc_pkg::CMD_SW_STORE, 15'h0000, 8'h00);
      check_stores(1);
      run_cmd(nvc_pkg::CMD_WRITE, 15'h0123, 8'h5A);
      run_cmd(nvc_pkg::CMD_SW_RECALL, 15'h0000, 8'h00);
      run_cmd(nvc_pkg::CMD_READ, 15'h0123, 8'h00);
      check_byte("recalled data", 8'hA5, got);
      run_cmd(nvc_pkg::CMD_SW_STORE, 15'h0000, 8'h00);
      check_stores(2);
   endtask : t_sw
   task automatic t_hw;
      stores = u_nvc_dev_model.n_store;
      run_cmd(nvc_pkg::CMD_HW_STORE, 15'h0000, 8'h00);
      check_stores(0);
      run_cmd(nvc_pkg::CMD_WRITE, 15'h0200, 8'h77);
      run_cmd(nvc_pkg::CMD_HW_STORE, 15'h0000, 8'h00);
      check_stores(1);
      run_cmd(nvc_pkg::CMD_READ, 15'h0200, 8'h00);
      check_byte("data after store", 8'h77, got);
   endtask : t_hw
   task automatic t_seq;
      logic [14:0] sq [6] = '{nvc_pkg::SEQ_A0, nvc_pkg::SEQ_A1,
         nvc_pkg::SEQ_A2, nvc_pkg::SEQ_A3, nvc_pkg::SEQ_A4,
         nvc_pkg::SEQ_STORE};
      stores = u_nvc_dev_model.n_store;
      for (int i = 0; i < 6; i++) begin
         if (i == 5) run_cmd(nvc_pkg::CMD_WRITE, 15'h0300, 8'h99);
         run_cmd(nvc_pkg::CMD_READ, sq[i], 8'h00);
      end
      check_stores(0);
      for (int i = 0; i < 6; i++)
         run_cmd(nvc_pkg::CMD_READ, sq[i] | {i == 0, 14'h0000}, 8'h00);
      run_cmd(nvc_pkg::CMD_READ, 15'h0300, 8'h00);
      check_byte("data after sequence", 8'h99, got);
      check_stores(1);
   endtask : t_seq
   initial begin
      resetn = 1'b0;
      req_valid = 1'b0;
      req = '0;
      bad_count = 0;
      n_compared = 0;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      t_rw;
      t_sw;
      t_hw;
      t_seq;
      finish_test;
   end
   initial begin
      #200000;
      bad_count++;
      finish_test;
   end
endmodule : tb_top
